//--- hw/spfc_pkg.sv
package spfc_pkg;
  // prefix byte values
  localparam logic [7:0] PFX_ADDR_SIZE = 8'h67;
  localparam logic [7:0] PFX_OPND_SIZE = 8'h66;
  localparam logic [7:0] PFX_SEG_CS    = 8'h2e;
  localparam logic [7:0] PFX_SEG_SS    = 8'h36;
  localparam logic [7:0] PFX_SEG_DS    = 8'h3e;
  localparam logic [7:0] PFX_SEG_ES    = 8'h26;
  localparam logic [7:0] PFX_SEG_FS    = 8'h64;
  localparam logic [7:0] PFX_SEG_GS    = 8'h65;
  localparam logic [7:0] PFX_REP       = 8'hf3;
  localparam logic [7:0] PFX_REPNE     = 8'hf2;
  localparam logic [7:0] PFX_LOCK      = 8'hf0;
  localparam logic [7:0] NUMERIC_VECTOR = 8'h10;
  localparam logic [7:0] INVALID_OPCODE_VECTOR = 8'h06;
  localparam logic [7:0] PAGE_FAULT_VECTOR = 8'h0e;
  localparam logic [7:0] SEG_NP_VECTOR = 8'h0b;
  localparam logic [7:0] LIMIT_VECTOR = 8'h0d;
  localparam int unsigned FEATURE_BIT = 25;
  localparam logic [31:0] FEATURE_LEAF = 32'h0000_0001;
  localparam int unsigned WIDE_REGS_LEGACY = 8;
  localparam int unsigned WIDE_REGS_LONG = 16;
  localparam int unsigned WIDE_REG_W = 128;
  localparam int unsigned SP_LANES = 4;
  localparam int unsigned CSR_W = 32;
  localparam logic [31:0] CSR_RESET = 32'h0000_1f80;
  localparam logic [31:0] CSR_WR_MASK = 32'h0000_ffff;
  localparam int unsigned PKREG_N = 8;
  localparam int unsigned FP_REG_W = 80;
  localparam logic [1:0] TAG_VALID = 2'h0;
  localparam logic [1:0] TAG_EMPTY = 2'h3;
  localparam logic [15:0] EXP_ONES = 16'hffff;
  // segment selection codes
  localparam logic [2:0] SEG_ES = 3'h0;
  localparam logic [2:0] SEG_CS = 3'h1;
  localparam logic [2:0] SEG_SS = 3'h2;
  localparam logic [2:0] SEG_DS = 3'h3;
  localparam logic [2:0] SEG_FS = 3'h4;
  localparam logic [2:0] SEG_GS = 3'h5;
  // reserved prefix policy: 0 ignore, 1 fault
  localparam logic RESERVED_FAULTS = 1'b0;

  typedef enum logic [1:0] {
    SPFC_IDLE  = 2'b00,
    SPFC_CHECK = 2'b01,
    SPFC_DONE  = 2'b11,
    SPFC_WAIT  = 2'b10
  } spfc_state_t;
endpackage

//--- hw/spfc_pfx_if.sv
`timescale 1ns/100ps
interface spfc_pfx_if;
  logic [7:0] pfx_byte;
  logic       pfx_valid;
  logic       has_mem;
  logic       lock_seen;
  logic       addr_ovr;
  logic       seg_ovr;
  logic [2:0] seg_sel;
  logic       reserved_seen;
  modport decoder (input pfx_byte, pfx_valid, has_mem,
                   output lock_seen, addr_ovr, seg_ovr, seg_sel,
                   reserved_seen);
  modport core (output pfx_byte, pfx_valid, has_mem,
                input lock_seen, addr_ovr, seg_ovr, seg_sel,
                reserved_seen);
endinterface

//--- hw/spfc_pfx_dec.sv
`timescale 1ns/100ps
module spfc_pfx_dec (
  input  wire logic   clk_in,
  input  wire logic   rst_b_in,
  input  wire logic   ce_in,
  input  wire logic   clear_in,
  spfc_pfx_if.decoder pfx
);
  logic       lock_q;
  logic       addr_q;
  logic       seg_q;
  logic       rsv_q;
  logic [2:0] sel_q;
  logic       is_seg;
  logic       is_rsv;
  logic [2:0] sel_d;

  always_comb begin
    is_seg = 1'b1;
    is_rsv = 1'b0;
    sel_d  = sel_q;
    unique case (pfx.pfx_byte)
      spfc_pkg::PFX_SEG_ES: sel_d = spfc_pkg::SEG_ES;
      spfc_pkg::PFX_SEG_CS: sel_d = spfc_pkg::SEG_CS;
      spfc_pkg::PFX_SEG_SS: sel_d = spfc_pkg::SEG_SS;
      spfc_pkg::PFX_SEG_DS: sel_d = spfc_pkg::SEG_DS;
      spfc_pkg::PFX_SEG_FS: sel_d = spfc_pkg::SEG_FS;
      spfc_pkg::PFX_SEG_GS: sel_d = spfc_pkg::SEG_GS;
      spfc_pkg::PFX_OPND_SIZE,
      spfc_pkg::PFX_REP,
      spfc_pkg::PFX_REPNE: begin
        is_seg = 1'b0;
        is_rsv = 1'b1;
      end
      default: is_seg = 1'b0;
    endcase
  end

  // prefixes accumulate until the opcode clears them
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lock_q <= 1'b0;
      addr_q <= 1'b0;
      seg_q  <= 1'b0;
      rsv_q  <= 1'b0;
      sel_q  <= spfc_pkg::SEG_DS;
    end else if (ce_in) begin
      if (clear_in) begin
        lock_q <= 1'b0;
        addr_q <= 1'b0;
        seg_q  <= 1'b0;
        rsv_q  <= 1'b0;
        sel_q  <= spfc_pkg::SEG_DS;
      end
      // a prefix arriving with the op belongs to the next one: set wins
      if (pfx.pfx_valid) begin
        if (pfx.pfx_byte == spfc_pkg::PFX_LOCK)
          lock_q <= 1'b1;
        if (pfx.pfx_byte == spfc_pkg::PFX_ADDR_SIZE)
          addr_q <= 1'b1;
        if (is_seg) begin
          seg_q <= 1'b1;
          sel_q <= sel_d;
        end
        if (is_rsv)
          rsv_q <= 1'b1;
      end
    end
  end

  // without a memory operand these are reserved, and here simply ignored
  assign pfx.lock_seen     = lock_q;
  assign pfx.addr_ovr      = addr_q & pfx.has_mem;
  assign pfx.seg_ovr       = seg_q & pfx.has_mem;
  assign pfx.seg_sel       = sel_q;
  assign pfx.reserved_seen = rsv_q;
endmodule

//--- hw/spfc_core.sv
// What this block does
// - memory faults use the ordinary fault path
// - no numeric fault of its own
// - pending fp error faults next instruction
// - faulting instruction restarts, no effect first
// - packed registers alias floating-point storage
// - address-size prefix acts only with memory
// - segment override acts only with memory
// - size, repeat, hint prefixes are reserved
// - lock prefix gives invalid-opcode fault
// - feature query leaf 1 sets bit 25
// - eight wide registers, sixteen in 64-bit
// - 32-bit control/status, saved and restored
// - wide register holds four single values
// - usable in every execution mode
`timescale 1ns/100ps
module spfc_core (
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  input  wire logic         ce_in,
  input  wire logic [7:0]   pfx_byte_in,
  input  wire logic         pfx_valid_in,
  input  wire logic         op_valid_in,
  input  wire logic         op_has_mem_in,
  input  wire logic         op_writes_in,
  input  wire logic [2:0]   op_dst_in,
  input  wire logic [63:0]  op_result_in,
  input  wire logic         fp_pend_in,
  input  wire logic         numeric_vec_en_in,
  input  wire logic         mem_pf_in,
  input  wire logic         mem_np_in,
  input  wire logic         mem_lim_in,
  input  wire logic         handler_ret_in,
  input  wire logic         query_in,
  input  wire logic [31:0]  query_leaf_in,
  input  wire logic         long_mode_in,
  input  wire logic         csr_wr_in,
  input  wire logic [31:0]  csr_wdata_in,
  input  wire logic         fp_wr_in,
  input  wire logic [2:0]   fp_idx_in,
  input  wire logic [79:0]  fp_wdata_in,
  input  wire logic [2:0]   rd_idx_in,
  output logic              retire_out,
  output logic              fault_out,
  output logic [7:0]        fault_vec_out,
  output logic              numeric_error_pin_out,
  output logic              restart_out,
  output logic              addr_ovr_out,
  output logic              seg_ovr_out,
  output logic [2:0]        seg_sel_out,
  output logic [31:0]       query_edx_out,
  output logic [4:0]        wide_reg_count_out,
  output logic [31:0]       simd_fp_control_status_out,
  output logic              csr_gp_fault_out,
  output logic [79:0]       rd_data_out,
  output logic [1:0]        rd_tag_out,
  output logic [2:0]        fp_tos_out
);
  spfc_pfx_if pfx ();
  spfc_pkg::spfc_state_t state_q;
  logic [79:0] fp_regs_q [spfc_pkg::PKREG_N];
  logic [1:0]  fp_tags_q [spfc_pkg::PKREG_N];
  logic        done_op;
  logic        bad_op;

  // a wide register splits into four single-precision lanes
  localparam int unsigned SP_LANE_W =
    spfc_pkg::WIDE_REG_W / spfc_pkg::SP_LANES;

  assign pfx.pfx_byte  = pfx_byte_in;
  assign pfx.pfx_valid = pfx_valid_in;
  assign pfx.has_mem   = op_has_mem_in;

  spfc_pfx_dec u_dec (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .ce_in    (ce_in),
    .clear_in (done_op),
    .pfx      (pfx)
  );

  // decision is pure decode; mode inputs deliberately do not gate it
  assign bad_op = pfx.lock_seen |
                  (spfc_pkg::RESERVED_FAULTS & pfx.reserved_seen);
  assign done_op = op_valid_in & (state_q == spfc_pkg::SPFC_IDLE);

  // pending error holds until the handler returns, then the same op retries
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= spfc_pkg::SPFC_IDLE;
    end else if (ce_in) begin
      unique case (state_q)
        spfc_pkg::SPFC_IDLE:
          if (op_valid_in && fp_pend_in && !bad_op)
            state_q <= spfc_pkg::SPFC_WAIT;
        spfc_pkg::SPFC_WAIT:
          if (handler_ret_in)
            state_q <= spfc_pkg::SPFC_IDLE;
        // check and done codes are never entered; recover to idle
        default: state_q <= spfc_pkg::SPFC_IDLE;
      endcase
    end
  end

  // fault reporting and retire; nothing commits when any fault fires
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      retire_out            <= 1'b0;
      fault_out             <= 1'b0;
      fault_vec_out         <= 8'h00;
      numeric_error_pin_out <= 1'b0;
      restart_out           <= 1'b0;
      addr_ovr_out          <= 1'b0;
      seg_ovr_out           <= 1'b0;
      seg_sel_out           <= spfc_pkg::SEG_DS;
    end else if (ce_in) begin
      retire_out  <= 1'b0;
      fault_out   <= 1'b0;
      restart_out <= 1'b0;
      if (state_q == spfc_pkg::SPFC_WAIT && handler_ret_in) begin
        numeric_error_pin_out <= 1'b0;
        restart_out           <= 1'b1;
      end
      if (done_op) begin
        addr_ovr_out <= pfx.addr_ovr;
        seg_ovr_out  <= pfx.seg_ovr;
        seg_sel_out  <= pfx.seg_sel;
        if (bad_op) begin
          fault_out     <= 1'b1;
          fault_vec_out <= spfc_pkg::INVALID_OPCODE_VECTOR;
        end else if (fp_pend_in) begin
          // only a pending error yields a numeric fault
          fault_out             <= numeric_vec_en_in;
          fault_vec_out         <= spfc_pkg::NUMERIC_VECTOR;
          numeric_error_pin_out <= 1'b1;
        end else if (mem_pf_in) begin
          fault_out     <= 1'b1;
          fault_vec_out <= spfc_pkg::PAGE_FAULT_VECTOR;
        end else if (mem_np_in) begin
          fault_out     <= 1'b1;
          fault_vec_out <= spfc_pkg::SEG_NP_VECTOR;
        end else if (mem_lim_in) begin
          fault_out     <= 1'b1;
          fault_vec_out <= spfc_pkg::LIMIT_VECTOR;
        end else begin
          retire_out <= 1'b1;
        end
      end
    end
  end

  logic commit;
  assign commit = done_op & ~bad_op & ~fp_pend_in & ~mem_pf_in &
                  ~mem_np_in & ~mem_lim_in;

  // shared storage: packed ops write mantissa plus all-ones exponent
  generate
    for (genvar i = 0; i < spfc_pkg::PKREG_N; i++) begin : g_fp
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          fp_regs_q[i] <= '0;
          fp_tags_q[i] <= spfc_pkg::TAG_EMPTY;
        end else if (ce_in) begin
          if (commit) begin
            fp_tags_q[i] <= spfc_pkg::TAG_VALID;
            if (op_writes_in && op_dst_in == 3'(i))
              fp_regs_q[i] <= {spfc_pkg::EXP_ONES, op_result_in};
          end else if (fp_wr_in && fp_idx_in == 3'(i)) begin
            fp_regs_q[i] <= fp_wdata_in;
            fp_tags_q[i] <= spfc_pkg::TAG_VALID;
          end
        end
      end
    end
  endgenerate

  // read port lags its select by one cycle
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_data_out <= '0;
      rd_tag_out  <= spfc_pkg::TAG_EMPTY;
      fp_tos_out  <= 3'h0;
    end else if (ce_in) begin
      rd_data_out <= fp_regs_q[rd_idx_in];
      rd_tag_out  <= fp_tags_q[rd_idx_in];
      if (commit)
        fp_tos_out <= 3'h0;
    end
  end

  // feature query and register count for the wide extension
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      query_edx_out      <= 32'h0;
      wide_reg_count_out <= 5'(spfc_pkg::WIDE_REGS_LEGACY);
    end else if (ce_in) begin
      if (query_in)
        query_edx_out <= (query_leaf_in == spfc_pkg::FEATURE_LEAF) ?
                         (32'h1 << spfc_pkg::FEATURE_BIT) : 32'h0;
      wide_reg_count_out <= long_mode_in ?
        5'(spfc_pkg::WIDE_REGS_LONG) :
        5'(spfc_pkg::WIDE_REGS_LEGACY);
    end
  end

  // control/status word; high half reserved, nonzero write refused
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      simd_fp_control_status_out <= spfc_pkg::CSR_RESET;
      csr_gp_fault_out           <= 1'b0;
    end else if (ce_in) begin
      csr_gp_fault_out <= 1'b0;
      if (csr_wr_in) begin
        if ((csr_wdata_in & ~spfc_pkg::CSR_WR_MASK) != 32'h0)
          csr_gp_fault_out <= 1'b1;
        else
          simd_fp_control_status_out <= csr_wdata_in;
      end
    end
  end
endmodule

//--- verification/spfc_chk.sv
`timescale 1ns/100ps
module spfc_chk (
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  input wire logic        ce_in,
  input wire logic [7:0]  pfx_byte_in,
  input wire logic        pfx_valid_in,
  input wire logic        op_valid_in,
  input wire logic        op_has_mem_in,
  input wire logic        handler_ret_in,
  input wire logic        query_in,
  input wire logic [31:0] query_leaf_in,
  input wire logic        long_mode_in,
  input wire logic        csr_wr_in,
  input wire logic [31:0] csr_wdata_in,
  input wire logic        retire_out,
  input wire logic        fault_out,
  input wire logic [7:0]  fault_vec_out,
  input wire logic        numeric_error_pin_out,
  input wire logic        restart_out,
  input wire logic        addr_ovr_out,
  input wire logic        seg_ovr_out,
  input wire logic [31:0] query_edx_out,
  input wire logic [4:0]  wide_reg_count_out,
  input wire logic [31:0] simd_fp_control_status_out,
  input wire logic        csr_gp_fault_out
);
  logic       lock_q;
  logic       mem_q;
  logic [1:0] up_q;

  default clocking dcb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  // lock prefix memory near the decoder's: cleared by any op under ce_in, even one refused while waiting, and clear wins over a lock
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in) lock_q <= 1'b0;
    else if (ce_in && op_valid_in) lock_q <= 1'b0;
    else if (ce_in && pfx_valid_in && pfx_byte_in == spfc_pkg::PFX_LOCK)
      lock_q <= 1'b1;

  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in) mem_q <= 1'b0;
    else if (ce_in && op_valid_in) mem_q <= op_has_mem_in;

  // count output lags the mode input, so wait out reset release first
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;

  sequence s_lock_op;
    ce_in && op_valid_in && lock_q && !numeric_error_pin_out;
  endsequence
  sequence s_inv_op;
    fault_out && fault_vec_out == spfc_pkg::INVALID_OPCODE_VECTOR;
  endsequence
  sequence s_ret;
    ce_in && handler_ret_in && numeric_error_pin_out;
  endsequence

  AST_LOCK_REFUSED: assert property (
    s_lock_op |-> ##[1:2] s_inv_op) else $error("lock prefix not refused");
  AST_NUM_VEC: assert property (
    fault_out && $rose(numeric_error_pin_out) |->
      fault_vec_out == spfc_pkg::NUMERIC_VECTOR) else $error("bad vector");
  AST_PIN_HOLD: assert property (
    numeric_error_pin_out && !handler_ret_in && !$past(handler_ret_in) |=>
      numeric_error_pin_out) else $error("error pin dropped");
  AST_WAIT_QUIET: assert property (
    $past(numeric_error_pin_out) && numeric_error_pin_out |->
      !retire_out && !fault_out) else $error("op ran while waiting");
  AST_RESTART: assert property (
    s_ret |-> ##[1:2] restart_out) else $error("no restart");
  AST_MEMLESS: assert property (
    retire_out && !mem_q |-> (!addr_ovr_out && !seg_ovr_out))
    else $error("override without memory operand");
  AST_CSR_GP: assert property (
    ce_in && csr_wr_in && csr_wdata_in[31:16] != 16'h0 |-> ##[1:2]
      (csr_gp_fault_out && simd_fp_control_status_out[31:16] == 16'h0))
    else $error("reserved csr write accepted");
  AST_QUERY: assert property (
    ce_in && query_in && query_leaf_in == spfc_pkg::FEATURE_LEAF |->
      ##[1:2] query_edx_out == 32'h0200_0000) else $error("feature bit");
  AST_COUNT: assert property (
    long_mode_in && $past(long_mode_in) && $past(long_mode_in, 2) &&
      up_q == 2'h3 |-> wide_reg_count_out == 5'h10) else $error("reg count");
endmodule

bind spfc_core spfc_chk i_spfc_chk (.*);

//--- verification/simd_int_prefix_fault_check_bench.sv
`timescale 1ns/100ps
module simd_int_prefix_fault_check_bench;
  logic        clk_in, rst_b_in, ce_in, pfx_valid_in, op_valid_in;
  logic        op_has_mem_in, op_writes_in, fp_pend_in, numeric_vec_en_in;
  logic        mem_pf_in, mem_np_in, mem_lim_in, handler_ret_in, query_in;
  logic        long_mode_in, csr_wr_in, fp_wr_in, gp;
  logic [7:0]  pfx_byte_in, fault_vec_out;
  logic [2:0]  op_dst_in, fp_idx_in, rd_idx_in, seg_sel_out, fp_tos_out;
  logic [63:0] op_result_in;
  logic [31:0] query_leaf_in, csr_wdata_in, query_edx_out;
  logic [31:0] simd_fp_control_status_out;
  logic [79:0] fp_wdata_in, rd_data_out;
  logic        retire_out, fault_out, numeric_error_pin_out, restart_out;
  logic        addr_ovr_out, seg_ovr_out, csr_gp_fault_out;
  logic [4:0]  wide_reg_count_out;
  logic [1:0]  rd_tag_out, got;
  logic [15:0] rnd;
  logic [3:0]  sg;
  int          mismatches, check_count, i, n;
  logic [7:0]  tbl [10] = '{8'h67, 8'h66, 8'h2e, 8'h36, 8'h3e, 8'h26,
                            8'h64, 8'h65, 8'hf3, 8'hf2};

  spfc_core i_spfc_core (.*);

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic logic [7:0] exp_vec(input logic [2:0] f);
    if (f[0]) return 8'h0e;
    if (f[1]) return 8'h0b;
    return 8'h0d;
  endfunction

  // {override hit, segment code}
  function automatic logic [3:0] seg_of(input logic [7:0] p);
    case (p)
      8'h26: return 4'h8;
      8'h2e: return 4'h9;
      8'h36: return 4'ha;
      8'h3e: return 4'hb;
      8'h64: return 4'hc;
      8'h65: return 4'hd;
      default: return 4'h0;
    endcase
  endfunction

  task automatic cmp(input string nm, input logic [95:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
      mismatches++;
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic pfx(input logic [7:0] p);
    @(posedge clk_in);
    pfx_byte_in <= p;
    pfx_valid_in <= 1'b1;
    @(posedge clk_in);
    pfx_valid_in <= 1'b0;
  endtask

  // pin-only numeric reports give no pulse, so a rising pin counts too
  task automatic op(input logic m, input logic [2:0] f, input logic want);
    logic p0;
    logic hit;
    p0 = numeric_error_pin_out;
    hit = 1'b0;
    @(posedge clk_in);
    op_valid_in <= 1'b1;
    op_has_mem_in <= m;
    {mem_lim_in, mem_np_in, mem_pf_in} <= f;
    @(posedge clk_in);
    op_valid_in <= 1'b0;
    {mem_lim_in, mem_np_in, mem_pf_in} <= 3'h0;
    for (n = 0; n < 6 && !hit; n++) begin
      #1;
      hit = retire_out || fault_out || (numeric_error_pin_out && !p0);
      got = {retire_out, fault_out};
      if (!hit) @(posedge clk_in);
    end
    if (want && !hit) begin
      mismatches++;
      test_done;
    end
  endtask

  task automatic csr_write(input logic [31:0] d);
    @(posedge clk_in);
    csr_wr_in <= 1'b1;
    csr_wdata_in <= d;
    @(posedge clk_in);
    csr_wr_in <= 1'b0;
    gp = 1'b0;
    for (n = 0; n < 3; n++) begin
      #1;
      gp = gp | csr_gp_fault_out;
      @(posedge clk_in);
    end
    #1;
  endtask

  initial begin
    {pfx_valid_in, op_valid_in, op_has_mem_in, op_writes_in} = '0;
    {fp_pend_in, numeric_vec_en_in, mem_pf_in, mem_np_in, mem_lim_in} = '0;
    {handler_ret_in, query_in, long_mode_in, csr_wr_in, fp_wr_in} = '0;
    {pfx_byte_in, op_dst_in, fp_idx_in, rd_idx_in, op_result_in} = '0;
    {query_leaf_in, csr_wdata_in, fp_wdata_in} = '0;
    {rst_b_in, mismatches, check_count} = '0;
    ce_in = 1'b1;
    rnd = 16'h0011;
    repeat (16) @(posedge clk_in);
    #1;
    cmp("regs", wide_reg_count_out, 5'h8);
    cmp("csr", simd_fp_control_status_out, 32'h1f80);
    cmp("tag", rd_tag_out, 2'h3);
    @(posedge clk_in);
    rst_b_in <= 1'b1;
    pfx(8'hf0);
    fp_pend_in <= 1'b1;
    op(1'b1, 3'h7, 1'b1);
    cmp("lock", {numeric_error_pin_out, got, fault_vec_out},
        11'h106);
    fp_pend_in <= 1'b0;
    for (i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      op(rnd[0], rnd[0] ? rnd[3:1] : 3'h0, 1'b1);
      if (rnd[0] && rnd[3:1] != 3'h0)
        cmp("mem", {got, fault_vec_out},
            {2'h1, exp_vec(rnd[3:1])});
      else
        cmp("plain", got, 2'h2);
    end
    for (i = 0; i < 20; i++) begin
      sg = seg_of(tbl[i % 10]);
      pfx(tbl[i % 10]);
      op(i >= 10, 3'h0, 1'b1);
      @(posedge clk_in);
      #1;
      cmp("reserved", got, 2'h2);
      cmp("addr", addr_ovr_out, i >= 10 && tbl[i % 10] == 8'h67);
      cmp("seg", seg_ovr_out, i >= 10 && sg[3]);
      if (i >= 10 && sg[3]) cmp("seg_sel", seg_sel_out, sg[2:0]);
    end
    for (i = 0; i < 2; i++) begin
      numeric_vec_en_in <= i[0];
      fp_pend_in <= 1'b1;
      op(1'b0, 3'h0, 1'b1);
      cmp("num", {numeric_error_pin_out, got}, {2'h2, i[0]});
      if (i == 1) cmp("num_vec", fault_vec_out, 8'h10);
      op(1'b0, 3'h0, 1'b0);
      cmp("refused", got, 2'h0);
      fp_pend_in <= 1'b0;
      @(posedge clk_in);
      handler_ret_in <= 1'b1;
      @(posedge clk_in);
      handler_ret_in <= 1'b0;
      for (n = 0; n < 4; n++) begin
        #1;
        if (restart_out) break;
        @(posedge clk_in);
      end
      cmp("restart", restart_out, 1'b1);
      op(1'b0, 3'h0, 1'b1);
      cmp("resume", {numeric_error_pin_out, got}, 3'h2);
    end
    // frozen clock enable: neither the prefix nor the op may land
    @(posedge clk_in);
    ce_in <= 1'b0;
    pfx(8'hf0);
    op(1'b0, 3'h0, 1'b0);
    cmp("frozen", got, 2'h0);
    ce_in <= 1'b1;
    op(1'b0, 3'h0, 1'b1);
    cmp("thawed", got, 2'h2);
    rnd = lfsr(rnd);
    @(posedge clk_in);
    fp_wr_in <= 1'b1;
    fp_idx_in <= rnd[2:0];
    rd_idx_in <= rnd[2:0];
    fp_wdata_in <= {rnd, 64'h0123_4567_89ab_cdef};
    @(posedge clk_in);
    fp_wr_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    cmp("fp_rd", rd_data_out, {rnd, 64'h0123_4567_89ab_cdef});
    op_writes_in <= 1'b1;
    op_dst_in <= rnd[2:0];
    op_result_in <= {4{rnd}};
    op(1'b0, 3'h0, 1'b1);
    op_writes_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    cmp("alias", {rd_data_out, rd_tag_out, fp_tos_out},
        {16'hffff, {4{rnd}}, 5'h0});
    for (i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      @(posedge clk_in);
      query_in <= 1'b1;
      query_leaf_in <= i[0] ? 32'h1 : {rnd, 16'h0};
      @(posedge clk_in);
      query_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      #1;
      cmp("query", query_edx_out, i[0] ? 32'h0200_0000 : 32'h0);
    end
    for (i = 0; i < 3; i++) begin
      @(posedge clk_in);
      long_mode_in <= i[0];
      repeat (3) @(posedge clk_in);
      #1;
      cmp("regs", wide_reg_count_out, i[0] ? 5'h10 : 5'h8);
      op(1'b0, 3'h0, 1'b1);
      cmp("any_mode", got, 2'h2);
    end
    rnd = lfsr(rnd);
    csr_write({16'h0, rnd});
    cmp("csr_wr", {gp, simd_fp_control_status_out}, {17'h0, rnd});
    csr_write({rnd, ~rnd});
    cmp("csr_gp", {gp, simd_fp_control_status_out},
        {17'h1_0000, rnd});
    test_done;
  end
endmodule
